// [include/spp_pkg.sv]
// Constants, register indices and types for the shared-pin parallel port.
// Assumes a classic Wishbone slave with 32-bit data and word-aligned registers.
// Overview of operation
// - Per pin, a mux pair picks peripheral or port for output data and enable.
// - Port's own driven output never reaches the input of a sharing peripheral.
// - Driving peripheral disables the port driver; pin level stays readable.
// - Enabled but idle peripheral leaves the pin to port direction and latch.
// - Direction bit one means input, zero means output.
// - Reset sets every implemented direction bit, so all pins are inputs.
// - Latch register reads return latch contents; writes update the latch.
// - Pin level register reads return pins; writes update the output latch.
// - Bits absent on a variant read zero in latch, direction and pin reads.
// - Latch and pin synchroniser contents reset to zero; open-drain resets to zero.
// - Unimplemented bit positions ignore writes and read back as zero.
// - Pin shared only with an input function behaves as a dedicated port pin.
package spp_pkg;

  // ==========================================================================
  // Geometry
  localparam int SPP_PORTS = 3;
  localparam int SPP_W     = 16;
  localparam int SPP_AW    = 16;
  localparam int PORT_D    = 0;
  localparam int PORT_E    = 1;
  localparam int PORT_F    = 2;

  // ==========================================================================
  // Register indices, byte address is four times the index
  localparam logic [13:0] IDX_NONE = 14'h0000;
  localparam logic [SPP_PORTS-1:0][13:0] IDX_DIR = {14'h02de, 14'h02d8, 14'h02d2};
  localparam logic [SPP_PORTS-1:0][13:0] IDX_PIN = {14'h02e0, 14'h02da, 14'h02d4};
  localparam logic [SPP_PORTS-1:0][13:0] IDX_LAT = {14'h02e2, 14'h02dc, 14'h02d6};
  localparam logic [SPP_PORTS-1:0][13:0] IDX_ODC = {14'h06de, IDX_NONE, 14'h06d2};
  localparam logic [SPP_PORTS-1:0]       ODC_VALID = 3'b101;

  // ==========================================================================
  // Implemented bits and reset values
  localparam logic [SPP_PORTS-1:0][15:0] PORT_MASK = {16'h31ff, 16'h00ff, 16'hffff};
  localparam logic [SPP_PORTS-1:0][15:0] DIR_RST   = {16'h31ff, 16'h00ff, 16'hffff};
  localparam logic [15:0]                LAT_RST   = 16'h0000;
  localparam logic [15:0]                ODC_RST   = 16'h0000;

  // ==========================================================================
  // Bus handshake states
  typedef enum logic {
    SPP_IDLE = 1'b0,
    SPP_ACK  = 1'b1
  } spp_bus_t;

endpackage

// [logic/spp_sync2.sv]
// Two-flop synchroniser for a vector of pin inputs.
// Assumes each bit is an independent level from outside the mclk domain.
`timescale 1ns/10ps
module spp_sync2 #(
  parameter int W = 16
) (
  input  wire logic         mclk,
  input  wire logic         sys_rst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] meta_q;

  // ==========================================================================
  // First stage feeds only the second
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      meta_q <= '0;
      dout   <= '0;
    end else begin
      meta_q <= din;
      dout   <= meta_q;
    end
  end

endmodule // spp_sync2

// [logic/spp_pin_mux.sv]
// Ownership multiplexer, open-drain control and loop-through block for one port.
// Assumes pinSync is already synchronised to mclk.
`timescale 1ns/10ps
module spp_pin_mux #(
  parameter int          W    = 16,
  parameter logic [15:0] MASK = 16'hffff
) (
  input  wire logic [W-1:0] dirBits,
  input  wire logic [W-1:0] latBits,
  input  wire logic [W-1:0] odBits,
  input  wire logic [W-1:0] perOwn,
  input  wire logic [W-1:0] perData,
  input  wire logic [W-1:0] perOe,
  input  wire logic [W-1:0] pinSync,
  output logic      [W-1:0] pinOut,
  output logic      [W-1:0] pinOe,
  output logic      [W-1:0] perIn
);

  logic [W-1:0] portOe;
  logic [W-1:0] portOut;

  // ==========================================================================
  // Port driver
  assign portOe  = ~dirBits & ~(odBits & latBits);
  assign portOut = latBits & ~odBits;

  // ==========================================================================
  // Ownership mux pair
  assign pinOe  = MASK[W-1:0] & ((perOwn & perOe) | (~perOwn & portOe));
  assign pinOut = MASK[W-1:0] & ((perOwn & perData) | (~perOwn & portOut));

  // ==========================================================================
  // Peripheral input, blanked while the port drives the pin
  assign perIn = MASK[W-1:0] & pinSync & ~(~perOwn & portOe);

endmodule // spp_pin_mux

// [logic/spp_parallel_port.sv]
// Shared-pin parallel port: three ports with direction and latch, open drain on ports D and F only.
// Assumes a classic Wishbone master and pins that are asynchronous to mclk.
//
// Implementation choice: the Wishbone interface to the registers.
`timescale 1ns/10ps
module spp_parallel_port
  import spp_pkg::*;
(
  input  wire logic                          mclk,
  input  wire logic                          sys_rst,
  input  wire logic [SPP_AW-1:0]             wb_adr_i,
  input  wire logic [31:0]                   wb_dat_i,
  input  wire logic [3:0]                    wb_sel_i,
  input  wire logic                          wb_we_i,
  input  wire logic                          wb_cyc_i,
  input  wire logic                          wb_stb_i,
  output logic      [31:0]                   wb_dat_o,
  output logic                               wb_ack_o,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] pinIn,
  output logic      [SPP_PORTS-1:0][SPP_W-1:0] pinOut,
  output logic      [SPP_PORTS-1:0][SPP_W-1:0] pinOe,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] perOwn,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] perData,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] perOe,
  output logic      [SPP_PORTS-1:0][SPP_W-1:0] perIn
);

  // ==========================================================================
  // Declarations
  spp_bus_t                    bus_q;
  logic [SPP_PORTS-1:0][15:0]  dir_q;
  logic [SPP_PORTS-1:0][15:0]  lat_q;
  logic [SPP_PORTS-1:0][15:0]  od_q;
  logic [SPP_PORTS-1:0][15:0]  pinSync;
  logic [31:0]                 rdat_q;
  logic [15:0]                 rdat_d;
  logic                        busReq;
  logic                        wrTake;

  // ==========================================================================
  // Helpers
  function automatic logic sppHit(input logic [SPP_AW-1:0] adr,
                                  input logic [13:0] idx);
    sppHit = (adr[SPP_AW-1:2] == idx);
  endfunction

  function automatic logic [15:0] sppMerge(input logic [15:0] old,
                                           input logic [31:0] wdat,
                                           input logic [3:0]  sel,
                                           input logic [15:0] mask);
    logic [15:0] merged;
    merged[7:0]  = sel[0] ? wdat[7:0]  : old[7:0];
    merged[15:8] = sel[1] ? wdat[15:8] : old[15:8];
    sppMerge = merged & mask;
  endfunction

  // ==========================================================================
  // Wishbone handshake
  assign busReq = wb_cyc_i && wb_stb_i;
  assign wrTake = (bus_q == SPP_ACK) && busReq && wb_we_i;

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      bus_q <= SPP_IDLE;
    end else begin
      case (bus_q)
        SPP_IDLE: begin
          if (busReq) begin
            bus_q <= SPP_ACK;
          end
        end
        SPP_ACK: begin
          bus_q <= SPP_IDLE;
        end
        default: begin
          bus_q <= SPP_IDLE;
        end
      endcase
    end
  end

  assign wb_ack_o = (bus_q == SPP_ACK);

  // ==========================================================================
  // Pin synchronisers
  spp_sync2 #(
    .W(SPP_PORTS*SPP_W)
  ) u_sync (
    .mclk    (mclk),
    .sys_rst (sys_rst),
    .din     (pinIn),
    .dout    (pinSync)
  );

  // ==========================================================================
  // Direction registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      dir_q <= DIR_RST;
    end else if (wrTake) begin
      for (int p = 0; p < SPP_PORTS; p++) begin
        if (sppHit(wb_adr_i, IDX_DIR[p])) begin
          dir_q[p] <= sppMerge(dir_q[p], wb_dat_i, wb_sel_i, PORT_MASK[p]);
        end
      end
    end
  end

  // ==========================================================================
  // Output latches, written through the latch or the pin level address
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int p = 0; p < SPP_PORTS; p++) begin
        lat_q[p] <= LAT_RST;
      end
    end else if (wrTake) begin
      for (int p = 0; p < SPP_PORTS; p++) begin
        if (sppHit(wb_adr_i, IDX_LAT[p]) || sppHit(wb_adr_i, IDX_PIN[p])) begin
          lat_q[p] <= sppMerge(lat_q[p], wb_dat_i, wb_sel_i, PORT_MASK[p]);
        end
      end
    end
  end

  // ==========================================================================
  // Open-drain select registers
  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      for (int p = 0; p < SPP_PORTS; p++) begin
        od_q[p] <= ODC_RST;
      end
    end else if (wrTake) begin
      for (int p = 0; p < SPP_PORTS; p++) begin
        if (ODC_VALID[p] && sppHit(wb_adr_i, IDX_ODC[p])) begin
          od_q[p] <= sppMerge(od_q[p], wb_dat_i, wb_sel_i, PORT_MASK[p]);
        end
      end
    end
  end

  // ==========================================================================
  // Read path
  always_comb begin
    rdat_d = 16'h0000;
    for (int p = 0; p < SPP_PORTS; p++) begin
      if (sppHit(wb_adr_i, IDX_DIR[p])) begin
        rdat_d = dir_q[p] & PORT_MASK[p];
      end
      if (sppHit(wb_adr_i, IDX_PIN[p])) begin
        rdat_d = pinSync[p] & PORT_MASK[p];
      end
      if (sppHit(wb_adr_i, IDX_LAT[p])) begin
        rdat_d = lat_q[p] & PORT_MASK[p];
      end
      if (ODC_VALID[p] && sppHit(wb_adr_i, IDX_ODC[p])) begin
        rdat_d = od_q[p] & PORT_MASK[p];
      end
    end
  end

  always_ff @(posedge mclk) begin
    if (sys_rst) begin
      rdat_q <= 32'h0000_0000;
    end else if ((bus_q == SPP_IDLE) && busReq) begin
      rdat_q <= {16'h0000, rdat_d};
    end
  end

  assign wb_dat_o = rdat_q;

  // ==========================================================================
  // Per-port ownership muxes
  for (genvar g = 0; g < SPP_PORTS; g++) begin : g_port
    spp_pin_mux #(
      .W    (SPP_W),
      .MASK (PORT_MASK[g])
    ) u_mux (
      .dirBits (dir_q[g]),
      .latBits (lat_q[g]),
      .odBits  (od_q[g]),
      .perOwn  (perOwn[g]),
      .perData (perData[g]),
      .perOe   (perOe[g]),
      .pinSync (pinSync[g]),
      .pinOut  (pinOut[g]),
      .pinOe   (pinOe[g]),
      .perIn   (perIn[g])
    );
  end

  // ==========================================================================
  // Assertions
  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (sys_rst);

  sequence seqReq(logic [13:0] idx);
    (bus_q == SPP_IDLE) && busReq && sppHit(wb_adr_i, idx);
  endsequence

  sequence seqWrite(logic [13:0] idx);
    wrTake && sppHit(wb_adr_i, idx) && (wb_sel_i[1:0] == 2'b11);
  endsequence

  property pAckOnce;
    (bus_q == SPP_IDLE) && busReq |=> wb_ack_o ##1 !wb_ack_o;
  endproperty

  AST_ACK_ONE_CYCLE: assert property (pAckOnce)
    else $error("ack is not a single cycle one edge after request");

  AST_DIR_RESET: assert property (disable iff (1'b0)
    $past(sys_rst) |-> (dir_q == DIR_RST))
    else $error("direction registers not all inputs after reset");

  AST_OD_RESET: assert property (disable iff (1'b0)
    $past(sys_rst) |-> (od_q[PORT_D] == 16'h0000) && (od_q[PORT_F] == 16'h0000))
    else $error("open-drain select not cleared by reset");

  AST_LATCH_WRITE: assert property (
    seqWrite(IDX_LAT[PORT_D]) |=>
      ({16'h0000, lat_q[PORT_D]} == ($past(wb_dat_i) & {16'h0000, PORT_MASK[PORT_D]})))
    else $error("latch write did not land in the latch");

  AST_PIN_WRITE_TO_LATCH: assert property (
    seqWrite(IDX_PIN[PORT_F]) |=>
      ({16'h0000, lat_q[PORT_F]} == ($past(wb_dat_i) & {16'h0000, PORT_MASK[PORT_F]})))
    else $error("pin level write did not update the latch");

  AST_PIN_READ: assert property (
    seqReq(IDX_PIN[PORT_D]) |=>
      wb_ack_o && (wb_dat_o[15:0] == $past(pinSync[PORT_D])))
    else $error("pin level read does not show the synchronised pins");

  AST_LATCH_READ_E: assert property (
    seqReq(IDX_LAT[PORT_E]) |=> wb_ack_o && (wb_dat_o[15:8] == 8'h00))
    else $error("absent bits of port E latch read non-zero");

  AST_UNIMPL_WRITE: assert property (
    seqWrite(IDX_DIR[PORT_F]) |=> ((dir_q[PORT_F] & ~PORT_MASK[PORT_F]) == 16'h0000))
    else $error("unimplemented direction bits took a write");

  AST_UNIMPL_OE: assert property (
    ((pinOe[PORT_E] & ~PORT_MASK[PORT_E]) == 16'h0000) &&
    ((pinOe[PORT_F] & ~PORT_MASK[PORT_F]) == 16'h0000))
    else $error("absent pin has its driver enabled");

  AST_PERIPH_OWNS: assert property (
    ((pinOe[PORT_D] & perOwn[PORT_D]) == (perOe[PORT_D] & perOwn[PORT_D])) &&
    ((pinOut[PORT_D] & perOwn[PORT_D]) == (perData[PORT_D] & perOwn[PORT_D])))
    else $error("owning peripheral does not control its pin");

  AST_PORT_OWNS: assert property (
    ((pinOe[PORT_D] & ~perOwn[PORT_D]) ==
     (~perOwn[PORT_D] & ~dir_q[PORT_D] & ~(od_q[PORT_D] & lat_q[PORT_D]))))
    else $error("port driver disagrees with direction and latch");

  AST_OPEN_DRAIN: assert property (
    ((pinOut[PORT_D] & ~perOwn[PORT_D] & od_q[PORT_D]) == 16'h0000))
    else $error("open-drain pin driven high");

  AST_NO_LOOP: assert property (
    ((perIn[PORT_D] & pinOe[PORT_D] & ~perOwn[PORT_D]) == 16'h0000))
    else $error("port output loops into peripheral input");

  AST_SYNC_TWO: assert property (
    !$past(sys_rst) && !$past(sys_rst, 2) |-> (pinSync == $past(pinIn, 2)))
    else $error("pin input not delayed by exactly two flops");

  // ==========================================================================
  // Further register and pin checks on ports D, E and F
  AST_LATCH_WRITE_E: assert property (
    seqWrite(IDX_LAT[PORT_E]) |=>
      (lat_q[PORT_E] == ($past(wb_dat_i[15:0]) & PORT_MASK[PORT_E])))
    else $error("port E latch write did not land in the latch");

  AST_LATCH_WRITE_F: assert property (
    seqWrite(IDX_LAT[PORT_F]) |=>
      (lat_q[PORT_F] == ($past(wb_dat_i[15:0]) & PORT_MASK[PORT_F])))
    else $error("port F latch write did not land in the latch");

  AST_PIN_WRITE_D: assert property (
    seqWrite(IDX_PIN[PORT_D]) |=>
      (lat_q[PORT_D] == $past(wb_dat_i[15:0])))
    else $error("port D pin level write did not update the latch");

  AST_PIN_WRITE_E: assert property (
    seqWrite(IDX_PIN[PORT_E]) |=>
      (lat_q[PORT_E] == ($past(wb_dat_i[15:0]) & PORT_MASK[PORT_E])))
    else $error("port E pin level write did not update the latch");

  AST_DIR_WRITE_D: assert property (
    seqWrite(IDX_DIR[PORT_D]) |=> (dir_q[PORT_D] == $past(wb_dat_i[15:0])))
    else $error("port D direction write did not land");

  AST_OD_WRITE_F: assert property (
    seqWrite(IDX_ODC[PORT_F]) |=>
      (od_q[PORT_F] == ($past(wb_dat_i[15:0]) & PORT_MASK[PORT_F])))
    else $error("port F open-drain write did not land");

  AST_PIN_READ_E: assert property (
    seqReq(IDX_PIN[PORT_E]) |=>
      wb_ack_o && (wb_dat_o[15:0] == ($past(pinSync[PORT_E]) & PORT_MASK[PORT_E])))
    else $error("port E pin level read wrong");

  AST_PIN_READ_F: assert property (
    seqReq(IDX_PIN[PORT_F]) |=>
      wb_ack_o && (wb_dat_o[15:0] == ($past(pinSync[PORT_F]) & PORT_MASK[PORT_F])))
    else $error("port F pin level read wrong");

  AST_LATCH_READ_D: assert property (
    seqReq(IDX_LAT[PORT_D]) |=>
      wb_ack_o && (wb_dat_o[15:0] == $past(lat_q[PORT_D])))
    else $error("port D latch read does not show the latch");

  AST_DIR_READ_F: assert property (
    seqReq(IDX_DIR[PORT_F]) |=>
      wb_ack_o && (wb_dat_o[15:0] == $past(dir_q[PORT_F])))
    else $error("port F direction read wrong");

  AST_OD_READ_D: assert property (
    seqReq(IDX_ODC[PORT_D]) |=>
      wb_ack_o && (wb_dat_o[15:0] == $past(od_q[PORT_D])))
    else $error("port D open-drain read wrong");

  AST_UNMAPPED_READ: assert property (
    seqReq(IDX_NONE) |=>
      wb_ack_o && (wb_dat_o == 32'h0000_0000))
    else $error("unmapped read returned non-zero data");

  AST_READ_UPPER_ZERO: assert property (
    wb_ack_o |-> (wb_dat_o[31:16] == 16'h0000))
    else $error("upper half of read data non-zero");

  AST_PERIPH_OWNS_F: assert property (
    ((pinOe[PORT_F] & perOwn[PORT_F]) ==
     (perOe[PORT_F] & perOwn[PORT_F] & PORT_MASK[PORT_F])))
    else $error("owning peripheral does not control its port F pin");

  AST_PORT_OWNS_E: assert property (
    ((pinOe[PORT_E] & ~perOwn[PORT_E]) ==
     (~perOwn[PORT_E] & ~dir_q[PORT_E] & PORT_MASK[PORT_E])))
    else $error("port E driver disagrees with direction");

  AST_OPEN_DRAIN_F: assert property (
    ((pinOut[PORT_F] & ~perOwn[PORT_F] & od_q[PORT_F]) == 16'h0000))
    else $error("port F open-drain pin driven high");

  AST_NO_LOOP_F: assert property (
    ((perIn[PORT_F] & pinOe[PORT_F] & ~perOwn[PORT_F]) == 16'h0000))
    else $error("port F output loops into peripheral input");

  AST_OWNER_SEES_PIN: assert property (
    ((perIn[PORT_D] & perOwn[PORT_D]) ==
     (pinSync[PORT_D] & perOwn[PORT_D])))
    else $error("owning peripheral cannot read its pin");

  AST_INPUT_ONLY_E: assert property (
    ((perIn[PORT_E] & ~perOwn[PORT_E] & dir_q[PORT_E]) ==
     (pinSync[PORT_E] & ~perOwn[PORT_E] & dir_q[PORT_E])))
    else $error("input pin level not passed to input-only user");

endmodule // spp_parallel_port

// [test/spp_pin_world.sv]
// Far-side model: outside drivers and pull-ups that resolve each pin level.
// Assumes pinOut and pinOe come from the port block, extVal and extOe from the bench.
`timescale 1ns/10ps
module spp_pin_world
  import spp_pkg::*;
(
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] pinOut,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] pinOe,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] extVal,
  input  wire logic [SPP_PORTS-1:0][SPP_W-1:0] extOe,
  output logic      [SPP_PORTS-1:0][SPP_W-1:0] pinIn
);
  // ==========================================================================
  // Pin resolution: device drive first, then outside drive, else pull-up
  always_comb begin
    for (int p = 0; p < SPP_PORTS; p++) begin
      pinIn[p] = (pinOe[p] & pinOut[p]) | (~pinOe[p] & extOe[p] & extVal[p])
               | (~pinOe[p] & ~extOe[p]);
    end
  end
endmodule // spp_pin_world

// [test/tb.sv]
// Testbench for the shared-pin parallel port, driven over classic Wishbone.
// Assumes the pin world model resolves pins; peripherals are driven here.
`timescale 1ns/10ps
module tb
  import spp_pkg::*;
;
  logic                               mclk;
  logic                               sys_rst;
  logic [SPP_AW-1:0]                  wb_adr_i;
  logic [31:0]                        wb_dat_i;
  logic [3:0]                         wb_sel_i;
  logic                               wb_we_i;
  logic                               wb_cyc_i;
  logic                               wb_stb_i;
  logic [31:0]                        wb_dat_o;
  logic                               wb_ack_o;
  logic [SPP_PORTS-1:0][SPP_W-1:0]    pinIn, pinOut, pinOe, perOwn, perData, perOe, perIn;
  logic [SPP_PORTS-1:0][SPP_W-1:0]    extVal, extOe;
  logic [SPP_PORTS-1:0][15:0]         implMask;
  int                                 errTotal;
  int                                 cmpCount;

  assign implMask = {16'h31ff, 16'h00ff, 16'hffff};

  spp_parallel_port dut_u (.mclk(mclk), .sys_rst(sys_rst), .wb_adr_i(wb_adr_i),
    .wb_dat_i(wb_dat_i), .wb_sel_i(wb_sel_i), .wb_we_i(wb_we_i), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .pinIn(pinIn),
    .pinOut(pinOut), .pinOe(pinOe), .perOwn(perOwn), .perData(perData), .perOe(perOe),
    .perIn(perIn));
  spp_pin_world world_u (.pinOut(pinOut), .pinOe(pinOe), .extVal(extVal), .extOe(extOe),
    .pinIn(pinIn));

  // ==========================================================================
  // Clock and watchdog
  initial begin
    mclk = 1'b0;
    forever #4 mclk = ~mclk;
  end

  initial begin
    repeat (20000) @(posedge mclk);
    errTotal++;
    completeRun();
  end

  // ==========================================================================
  // Shared tasks
  function automatic logic [15:0] ba(input logic [13:0] i);
    return {i, 2'b00};
  endfunction

  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    cmpCount++;
    if (seen !== exp) begin
      errTotal++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic pk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
    chk(nm, {16'h0000, seen}, {16'h0000, exp});
  endtask

  task automatic bus(input logic [15:0] a, input logic w, input logic [15:0] d,
                     input logic [3:0] s, output logic [31:0] r);
    int n;
    @(posedge mclk);
    wb_adr_i <= a;
    wb_we_i  <= w;
    wb_dat_i <= {16'h0000, d};
    wb_sel_i <= s;
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 16);
    r = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_we_i  <= 1'b0;
    if (n >= 16) begin
      errTotal++;
      $display("wrong value bus ack expected 1 seen 0");
    end
  endtask

  task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic [3:0] s = 4'b0011);
    logic [31:0] r;
    bus(a, 1'b1, d, s, r);
  endtask

  task automatic rd(input logic [15:0] a, input logic [15:0] e, input string nm);
    logic [31:0] r;
    bus(a, 1'b0, 16'h0000, 4'b1111, r);
    chk(nm, r, {16'h0000, e});
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask

  task completeRun;
    $display("Comparisons %0d, mismatches %0d", cmpCount, errTotal);
    if (errTotal == 0 && cmpCount > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask

  // ==========================================================================
  // Test sequence
  initial begin
    errTotal = 0;
    cmpCount = 0;
    sys_rst = 1'b1;
    {wb_adr_i, wb_dat_i, wb_sel_i, wb_we_i, wb_cyc_i, wb_stb_i} = '0;
    {perOwn, perData, perOe, extVal, extOe} = '0;
    repeat (10) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
    for (int p = 0; p < SPP_PORTS; p++) begin
      pk("output enable", pinOe[p], 16'h0000);
      rd(ba(IDX_DIR[p]), implMask[p], "direction");
      if (ODC_VALID[p]) rd(ba(IDX_ODC[p]), 16'h0000, "open drain");
    end
    // Latch masking, pin-level write path and output drive per port
    for (int p = 0; p < SPP_PORTS; p++) begin
      wr(ba(IDX_LAT[p]), 16'hffff);
      rd(ba(IDX_LAT[p]), implMask[p], "latch");
      wr(ba(IDX_DIR[p]), 16'h0000);
      wr(ba(IDX_PIN[p]), 16'h5a3c);
      rd(ba(IDX_LAT[p]), 16'h5a3c & implMask[p], "latch via pin");
      tick(3);
      pk("output enable", pinOe[p], implMask[p]);
      pk("pin out", pinOut[p], 16'h5a3c & implMask[p]);
      pk("loop through", perIn[p], 16'h0000);
      rd(ba(IDX_PIN[p]), 16'h5a3c & implMask[p], "pin level");
      if (ODC_VALID[p]) begin
        wr(ba(IDX_ODC[p]), 16'hffff);
        rd(ba(IDX_ODC[p]), implMask[p], "open drain");
        pk("od enable", pinOe[p], 16'ha5c3 & implMask[p]);
        pk("od out", pinOut[p], 16'h0000);
        rd(ba(IDX_PIN[p]), 16'h5a3c & implMask[p], "od pull-up");
        extOe[p] <= 16'hffff;
        tick(3);
        rd(ba(IDX_PIN[p]), 16'h0000, "od release");
        extOe[p] <= 16'h0000;
        wr(ba(IDX_ODC[p]), 16'h0000);
      end
    end
    // Byte lane write, then peripheral ownership on port D
    wr(ba(IDX_LAT[PORT_D]), 16'h1234, 4'b0001);
    rd(ba(IDX_LAT[PORT_D]), 16'h5a34, "byte lane");
    @(posedge mclk);
    perOwn[PORT_D]  <= 16'h00ff;
    perData[PORT_D] <= 16'h000f;
    perOe[PORT_D]   <= 16'h00f0;
    tick(3);
    pk("owned enable", pinOe[PORT_D], 16'hfff0);
    pk("owned out", pinOut[PORT_D], 16'h5a0f);
    pk("owned per in", perIn[PORT_D], 16'h000f);
    rd(ba(IDX_PIN[PORT_D]), 16'h5a0f, "owned pin");
    perOwn[PORT_D] <= 16'h0000;
    tick(1);
    pk("idle per enable", pinOe[PORT_D], 16'hffff);
    pk("idle per out", pinOut[PORT_D], 16'h5a34);
    // Input path through the synchroniser on port F
    wr(ba(IDX_DIR[PORT_F]), 16'hffff);
    rd(ba(IDX_DIR[PORT_F]), 16'h31ff, "direction mask");
    repeat (3) @(posedge mclk);
    extOe[PORT_F]  <= 16'hffff;
    extVal[PORT_F] <= 16'hc055;
    tick(1);
    pk("sync first", perIn[PORT_F], 16'h31ff);
    tick(1);
    pk("sync second", perIn[PORT_F], 16'h0055);
    rd(ba(IDX_PIN[PORT_F]), 16'h0055, "input pin");
    // Unmapped places read zero and ignore writes
    rd(16'h0000, 16'h0000, "unmapped");
    wr(ba(14'h06d8), 16'hffff);
    rd(ba(14'h06d8), 16'h0000, "port e od");
    // Reset in mid-run
    @(posedge mclk);
    sys_rst <= 1'b1;
    repeat (2) @(posedge mclk);
    sys_rst <= 1'b0;
    tick(1);
    pk("reset enable", pinOe[PORT_D], 16'h0000);
    rd(ba(IDX_DIR[PORT_D]), 16'hffff, "direction again");
    rd(ba(IDX_ODC[PORT_F]), 16'h0000, "open drain again");
    completeRun();
  end
endmodule // tb
